//--- inc/sbiu_pkg.sv
package sbiu_pkg;

  // core transfer sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // decoded targets: 0 none, 1 internal peripheral bus, 2..6 chip select 0..4
  localparam logic [2:0] TGT_NONE = 3'h0;
  localparam logic [2:0] TGT_IPB = 3'h1;
  localparam logic [2:0] TGT_CS0 = 3'h2;
  localparam int NUM_REGIONS = 6;
  localparam int NUM_CS = 5;

  // decode windows, index 0 = peripheral bus, 1..5 = chip select 0..4
  localparam logic [NUM_REGIONS-1:0][31:0] REGION_BASE_DEF = {
    32'h0200_0000, 32'h01c0_0000, 32'h0180_0000, 32'h0140_0000, 32'h0100_0000, 32'h0004_0000};
  localparam logic [NUM_REGIONS-1:0][31:0] REGION_MASK_DEF = {
    32'hffc0_0000, 32'hffc0_0000, 32'hffc0_0000, 32'hffc0_0000, 32'hffc0_0000, 32'hfffc_0000};
  // per chip select: 1 = 16-bit device, 0 = 8-bit device on the low lane
  localparam logic [NUM_CS-1:0] CS_BUS16_DEF = 5'h1f;

  localparam int EXT_ADDR_W = 22;
  localparam int EXT_DATA_W = 16;
  localparam int PIN_SYNC_STAGES = 3;
  localparam logic [4:0] CS_IDLE_N = 5'h1f;
  localparam logic [1:0] LANES_OFF = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD = 2'b10
  } sbiu_fsm_t;

  typedef struct packed {
    sbiu_fsm_t state;
    logic [2:0] tgt;
    logic wr;
    logic unit16;
    logic xb16;
    logic [1:0] beat;
    logic [1:0] last;
    logic [4:0] cnt;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic core_ack;
    logic core_err;
    logic [21:0] ext_addr;
    logic [15:0] ext_dout;
    logic ext_doe;
    logic ext_rd_n;
    logic ext_wr_n;
    logic [4:0] cs_n;
    logic [1:0] lanes;
    logic [1:0] bls_pin;
    logic [2:0] port_d_out;
    logic [2:0] port_d_oe;
    logic ipb_sel;
    logic ipb_we;
    logic [17:0] ipb_addr;
    logic [15:0] ipb_wdata;
    logic [1:0] ipb_be;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
  } sbiu_state_t;

  localparam sbiu_state_t SBIU_RESET = '{
    state: ST_IDLE,
    ext_rd_n: 1'b1,
    ext_wr_n: 1'b1,
    cs_n: CS_IDLE_N,
    bls_pin: 2'h3,
    default: '0
  };

endpackage

//--- rtl/sbiu_bus_interface_unit.sv
// How it works
// - core accesses of 32 bits are split into beats of 8 or 16 bits as the selected target is wide.
// - each core address is matched against the decode windows and the matching select is asserted.
// - peripheral window accesses go out on the internal peripheral bus, chip select window accesses on the external memory bus.
// - only the bus of the current access is driven; the other bus holds still with its drivers off.
// - the external memory bus carries 16 data lines and 22 address lines.
// - chip select 0 (flash) and chip select 1 (ram) leave on dedicated pins.
// - two byte lane selects mark the lower and upper byte so single bytes reach 16-bit memory.
// - port d pins 0..2 carry gpio when their function bit is 0 and chip selects 2..4 when it is 1.
// - on-chip ram and boot rom sit on the core bus directly and fall in no window of this unit.
// - read strobe is low while external data is read, write strobe low while it is written.
// - the byte lane select polarity follows the bls_active_high configuration bit, except in reset, which loads both pins high.
// - addresses are byte addresses with a[1:0] zero for words and a[0] zero for halfwords.
// - the peripheral bus stays idle during external accesses and serves 8 and 16 bit peripherals.
`timescale 1ns/1ps
`default_nettype none

module sbiu_bus_interface_unit #(
  parameter logic [sbiu_pkg::NUM_REGIONS-1:0][31:0] REGION_BASE = sbiu_pkg::REGION_BASE_DEF,
  parameter logic [sbiu_pkg::NUM_REGIONS-1:0][31:0] REGION_MASK = sbiu_pkg::REGION_MASK_DEF,
  parameter logic [sbiu_pkg::NUM_CS-1:0] CS_BUS16 = sbiu_pkg::CS_BUS16_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic core_req,
  input wire logic core_we,
  input wire logic [1:0] core_size,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_wdata,
  output logic core_ack,
  output logic core_err,
  output logic [31:0] core_rdata,
  input wire logic bls_active_high,
  input wire logic [3:0] ext_wait_states,
  output logic [sbiu_pkg::EXT_ADDR_W-1:0] ext_addr,
  output logic [sbiu_pkg::EXT_DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [sbiu_pkg::EXT_DATA_W-1:0] ext_data_in,
  output logic ext_read_n,
  output logic ext_write_n,
  output logic cs0_n,
  output logic cs1_n,
  output logic [1:0] byte_lane_select,
  input wire logic [2:0] port_d_func_sel,
  input wire logic [2:0] gpio_d_out,
  input wire logic [2:0] gpio_d_oe,
  output logic [2:0] port_d_out,
  output logic [2:0] port_d_oe,
  input wire logic ipb_port16,
  output logic ipb_sel,
  output logic ipb_we,
  output logic [17:0] ipb_addr,
  output logic [15:0] ipb_wdata,
  output logic [1:0] ipb_be,
  input wire logic [15:0] ipb_rdata,
  input wire logic ipb_ack
);
  import sbiu_pkg::*;

  sbiu_state_t q_ff;
  sbiu_state_t nxt_q;

  // first matching window wins, so two overlapping windows never raise two selects
  function automatic logic [2:0] decode_target(input logic [31:0] a);
    logic [2:0] hit;
    hit = TGT_NONE;
    for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
      if ((a & REGION_MASK[i]) == REGION_BASE[i]) begin
        hit = 3'(i + 1);
      end
    end
    return hit;
  endfunction

  logic is_ext;
  logic [31:0] beat_addr;
  logic [5:0] shamt;
  logic [15:0] wchunk;
  logic [15:0] bus_in;
  logic [15:0] rchunk;
  logic [2:0] cs_idx;
  logic [2:0] req_tgt;
  logic req_unit16;
  logic req_xb16;
  logic [1:0] req_last;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.core_ack = 1'b0;
    nxt_q.core_err = 1'b0;
    // external data pins pass three stages before use
    nxt_q.sync1 = ext_data_in;
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.sync3 = q_ff.sync2;

    is_ext = q_ff.tgt >= TGT_CS0;
    cs_idx = q_ff.tgt - TGT_CS0;
    beat_addr = q_ff.addr + (q_ff.xb16 ? {29'h0, q_ff.beat, 1'b0} : {30'h0, q_ff.beat});
    shamt = q_ff.xb16 ? {q_ff.beat, 4'h0} : {1'b0, q_ff.beat, 3'h0};
    wchunk = 16'(q_ff.wdata >> shamt);
    bus_in = is_ext ? q_ff.sync3 : ipb_rdata;
    if (q_ff.xb16) begin
      rchunk = bus_in;
    end else if (q_ff.unit16 && beat_addr[0]) begin
      rchunk = {8'h00, bus_in[15:8]};
    end else begin
      rchunk = {8'h00, bus_in[7:0]};
    end

    req_tgt = decode_target(core_addr);
    if (req_tgt == TGT_IPB) begin
      req_unit16 = ipb_port16;
    end else if (req_tgt >= TGT_CS0) begin
      req_unit16 = CS_BUS16[3'(req_tgt - TGT_CS0)];
    end else begin
      req_unit16 = 1'b0;
    end
    req_xb16 = req_unit16 && (core_size != SZ_BYTE);
    // beats minus one: word on 16 bits = 1, word on 8 bits = 3, half on 8 bits = 1
    if (core_size == SZ_WORD) begin
      req_last = req_xb16 ? 2'h1 : 2'h3;
    end else if (core_size == SZ_HALF) begin
      req_last = req_xb16 ? 2'h0 : 2'h1;
    end else begin
      req_last = 2'h0;
    end

    case (q_ff.state)
      ST_IDLE: begin
        if (core_req) begin
          if (req_tgt == TGT_NONE) begin
            nxt_q.core_ack = 1'b1;
            nxt_q.core_err = 1'b1;
          end else begin
            nxt_q.tgt = req_tgt;
            nxt_q.wr = core_we;
            nxt_q.unit16 = req_unit16;
            nxt_q.xb16 = req_xb16;
            nxt_q.last = req_last;
            nxt_q.beat = 2'h0;
            nxt_q.wdata = core_wdata;
            nxt_q.rdata = 32'h0;
            if (core_size == SZ_WORD) begin
              nxt_q.addr = {core_addr[31:2], 2'h0};
            end else if (core_size == SZ_HALF) begin
              nxt_q.addr = {core_addr[31:1], 1'b0};
            end else begin
              nxt_q.addr = core_addr;
            end
            nxt_q.state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (is_ext) begin
          nxt_q.ext_addr = beat_addr[EXT_ADDR_W-1:0];
          nxt_q.cs_n = CS_IDLE_N & ~(5'h01 << cs_idx);
          if (q_ff.xb16) begin
            nxt_q.lanes = 2'h3;
          end else if (q_ff.unit16 && beat_addr[0]) begin
            nxt_q.lanes = 2'h2;
          end else begin
            nxt_q.lanes = 2'h1;
          end
          // a byte is copied on both lanes; the lane selects pick the one that counts
          nxt_q.ext_dout = q_ff.xb16 ? wchunk : {wchunk[7:0], wchunk[7:0]};
          nxt_q.ext_doe = q_ff.wr;
          nxt_q.ext_rd_n = q_ff.wr;
          nxt_q.ext_wr_n = ~q_ff.wr;
          // strobe stretched by the pin synchroniser depth so read data is settled when caught
          nxt_q.cnt = 5'(ext_wait_states) + 5'(PIN_SYNC_STAGES);
        end else begin
          nxt_q.ipb_sel = 1'b1;
          nxt_q.ipb_we = q_ff.wr;
          nxt_q.ipb_addr = beat_addr[17:0];
          nxt_q.ipb_wdata = q_ff.xb16 ? wchunk : {wchunk[7:0], wchunk[7:0]};
          nxt_q.ipb_be = q_ff.xb16 ? 2'h3 : (q_ff.unit16 && beat_addr[0] ? 2'h2 : 2'h1);
        end
        nxt_q.state = ST_STROBE;
      end
      ST_STROBE: begin
        if (is_ext) begin
          if (q_ff.cnt == 5'h0) begin
            if (!q_ff.wr) begin
              nxt_q.rdata = q_ff.rdata | 32'({16'h0, rchunk} << shamt);
            end
            nxt_q.ext_rd_n = 1'b1;
            nxt_q.ext_wr_n = 1'b1;
            nxt_q.state = ST_HOLD;
          end else begin
            nxt_q.cnt = q_ff.cnt - 5'h1;
          end
        end else if (ipb_ack) begin
          if (!q_ff.wr) begin
            nxt_q.rdata = q_ff.rdata | 32'({16'h0, rchunk} << shamt);
          end
          nxt_q.ipb_sel = 1'b0;
          nxt_q.ipb_we = 1'b0;
          nxt_q.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // address and data lines keep their last value to avoid toggling
        nxt_q.cs_n = CS_IDLE_N;
        nxt_q.lanes = LANES_OFF;
        nxt_q.ext_doe = 1'b0;
        nxt_q.ipb_be = 2'h0;
        if (q_ff.beat == q_ff.last) begin
          nxt_q.core_ack = 1'b1;
          nxt_q.state = ST_IDLE;
        end else begin
          nxt_q.beat = q_ff.beat + 2'h1;
          nxt_q.state = ST_SETUP;
        end
      end
      default: begin
        nxt_q.state = ST_IDLE;
      end
    endcase

    nxt_q.bls_pin = bls_active_high ? nxt_q.lanes : ~nxt_q.lanes;
    for (int i = 0; i < 3; i++) begin
      nxt_q.port_d_out[i] = port_d_func_sel[i] ? nxt_q.cs_n[i + 2] : gpio_d_out[i];
      nxt_q.port_d_oe[i] = port_d_func_sel[i] ? 1'b1 : gpio_d_oe[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q_ff <= SBIU_RESET;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  assign core_ack = q_ff.core_ack;
  assign core_err = q_ff.core_err;
  assign core_rdata = q_ff.rdata;
  assign ext_addr = q_ff.ext_addr;
  assign ext_data_out = q_ff.ext_dout;
  assign ext_data_oe = q_ff.ext_doe;
  assign ext_read_n = q_ff.ext_rd_n;
  assign ext_write_n = q_ff.ext_wr_n;
  assign cs0_n = q_ff.cs_n[0];
  assign cs1_n = q_ff.cs_n[1];
  assign byte_lane_select = q_ff.bls_pin;
  assign port_d_out = q_ff.port_d_out;
  assign port_d_oe = q_ff.port_d_oe;
  assign ipb_sel = q_ff.ipb_sel;
  assign ipb_we = q_ff.ipb_we;
  assign ipb_addr = q_ff.ipb_addr;
  assign ipb_wdata = q_ff.ipb_wdata;
  assign ipb_be = q_ff.ipb_be;

endmodule

`default_nettype wire

//--- verif/sbiu_bus_interface_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbiu_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic core_ack,
  input wire logic core_err,
  input wire logic ext_data_oe,
  input wire logic ext_read_n,
  input wire logic ext_write_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] port_d_func_sel,
  input wire logic [2:0] gpio_d_out,
  input wire logic [2:0] gpio_d_oe,
  input wire logic [2:0] port_d_out,
  input wire logic [2:0] port_d_oe,
  input wire logic ipb_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_one_select: assert property (cs0_n || cs1_n) else $error("two chip selects low");
  a_ipb_idle_ext: assert property (!cs0_n || !cs1_n |-> !ipb_sel) else $error("ipb busy on ext");
  a_ext_idle_ipb: assert property (ipb_sel |-> ext_read_n && ext_write_n && !ext_data_oe)
    else $error("ext busy on ipb");
  a_read_released: assert property (!ext_read_n |-> !ext_data_oe && ext_write_n) else $error("read drives");
  a_write_driven: assert property (!ext_write_n |-> ext_data_oe) else $error("write undriven");
  a_strobe_min_len: assert property ($fell(ext_write_n) |-> (!ext_write_n) [*4]) else $error("short strobe");
  a_err_no_bus: assert property (core_err |-> core_ack && cs0_n && cs1_n && !$past(ipb_sel))
    else $error("err with bus");
  a_gpio_pass: assert property ($past(rst_n) |-> ((port_d_out ^ $past(gpio_d_out)) & ~$past(port_d_func_sel)) == 3'h0
    && ((port_d_oe ^ $past(gpio_d_oe)) & ~$past(port_d_func_sel)) == 3'h0) else $error("gpio lost");
  a_cs_pin_oe: assert property ($past(rst_n) |-> (port_d_oe & $past(port_d_func_sel)) == $past(port_d_func_sel))
    else $error("cs pin undriven");
  a_portd_cs_excl: assert property ($past(rst_n) && (($past(port_d_func_sel) & ~port_d_out) != 3'h0)
    |-> cs0_n && cs1_n && !ipb_sel) else $error("port d select overlaps");
  cover property ($fell(ext_write_n));
  cover property ($fell(ext_read_n));
  cover property (core_err);
  cover property (ipb_sel);
endmodule
bind sbiu_bus_interface_unit sbiu_chk u_sbiu_chk (.*);
`default_nettype wire

//--- verif/sbiu_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sbiu_mem (
  input wire logic clock,
  input wire logic [21:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_read_n,
  input wire logic ext_write_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [1:0] byte_lane_select,
  input wire logic bls_active_high,
  output logic [15:0] ext_data_in
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] k;
  logic [1:0] ln;
  assign k = {cs1_n, ext_addr[21:1]}; // flash and ram kept apart, 16-bit words
  assign ln = bls_active_high ? byte_lane_select : ~byte_lane_select;
  initial ext_data_in = 16'h0;
  // half a cycle after the strobe edge, so data is steady from strobe start
  always @(negedge clock) begin
    if (!mem.exists(k)) mem[k] = 16'h0;
    if (!ext_write_n && !(cs0_n && cs1_n) && ln[0]) mem[k][7:0] = ext_data_out[7:0];
    if (!ext_write_n && !(cs0_n && cs1_n) && ln[1]) mem[k][15:8] = ext_data_out[15:8];
    // a released bus must not keep the last value
    ext_data_in <= (!ext_read_n && !(cs0_n && cs1_n)) ? mem[k] : ~ext_data_in;
  end
endmodule
`default_nettype wire

//--- verif/test_system_bus_interface_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_bus_interface_unit;
  import sbiu_pkg::*;
  logic clock = 0, rst_n = 0, ce = 1, core_req = 0, core_we = 0, bls_active_high = 0, ipb_port16 = 0, ipb_ack = 0;
  logic [1:0] core_size = 0, byte_lane_select, ipb_be;
  logic [31:0] core_addr = 0, core_wdata = 0, core_rdata, d;
  logic [3:0] ext_wait_states = 0;
  logic [2:0] port_d_func_sel = 0, gpio_d_out = 0, gpio_d_oe = 0, port_d_out, port_d_oe;
  logic core_ack, core_err, ext_data_oe, ext_read_n, ext_write_n, cs0_n, cs1_n, ipb_sel, ipb_we;
  logic [21:0] ext_addr;
  logic [15:0] ext_data_out, ext_data_in, ipb_wdata, ipb_rdata;
  logic [17:0] ipb_addr;
  logic [32:0] n33;
  logic [33:0] q[$];
  int bad_count = 0, compares = 0;
  sbiu_bus_interface_unit u_sbiu_bus_interface_unit (.*);
  sbiu_mem u_sbiu_mem (.*);
  always #2.5 clock = ~clock;
  logic [15:0] ipb_mem [0:127];
  // reads with bit 9 set come from a small peripheral that every write reaches, the rest return their low address byte on both lanes
  assign ipb_rdata = ipb_addr[9] ? ipb_mem[ipb_addr[7:1]] : {2{ipb_addr[7:0]}};
  always @(posedge clock) if (ipb_sel && ipb_ack && ipb_we) begin
    if (ipb_be[0]) ipb_mem[ipb_addr[7:1]][7:0] <= ipb_wdata[7:0];
    if (ipb_be[1]) ipb_mem[ipb_addr[7:1]][15:8] <= ipb_wdata[15:8];
  end
  always @(posedge clock) ipb_ack <= ipb_sel && !ipb_ack;
  always @(posedge clock) {gpio_d_out, gpio_d_oe, port_d_func_sel} <= 9'($urandom);
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task acc(logic we, logic [1:0] sz, logic [31:0] a, logic [31:0] wd, logic [31:0] r, logic e);
    int n;
    q.push_back({!we, r, e});
    @(posedge clock);
    {core_req, core_we, core_size, core_addr, core_wdata} <= {1'b1, we, sz, a, wd};
    ext_wait_states <= 4'($urandom % 3);
    @(posedge clock);
    core_req <= 1'b0;
    // let the taking edge settle first, an unmapped access acks at that very edge
    #1;
    n = 0;
    while (core_ack !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    if (core_ack !== 1'b1) begin
      bad_count++;
      final_report;
    end
  endtask
  always @(negedge clock) if (core_ack === 1'b1) begin
    {n33[32], n33[31:0]} = {q[0][33], q[0][32:1]};
    chk("err", {31'h0, core_err}, {31'h0, q[0][0]});
    if (n33[32]) chk("rdata", core_rdata, n33[31:0]);
    void'(q.pop_front());
  end
  initial begin
    void'($urandom(32'he74e));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    acc(1, SZ_BYTE, 32'h0000_1000, 32'h11, 0, 1);
    acc(1, SZ_WORD, 32'h0300_0000, 32'h22, 0, 1);
    for (int p = 0; p < 2; p++) begin
      bls_active_high <= p[0];
      d = $urandom;
      acc(1, SZ_WORD, 32'h0140_0013, d, 0, 0);
      acc(1, SZ_BYTE, 32'h0140_0013, 32'h5a, 0, 0);
      acc(1, SZ_BYTE, 32'h0140_0010, 32'ha5, 0, 0);
      acc(0, SZ_WORD, 32'h0140_0010, 0, {8'h5a, d[23:8], 8'ha5}, 0);
      acc(0, SZ_HALF, 32'h0140_0011, 0, {16'h0, d[15:8], 8'ha5}, 0);
    end
    acc(1, SZ_HALF, 32'h0100_0007, d, 0, 0);
    acc(0, SZ_HALF, 32'h0100_0006, 0, {16'h0, d[15:0]}, 0);
    acc(0, SZ_HALF, 32'h0140_0006, 0, 0, 0);
    ipb_port16 <= 1'b0;
    acc(0, SZ_WORD, 32'h0004_0010, 0, 32'h1312_1110, 0);
    ipb_port16 <= 1'b1;
    acc(0, SZ_WORD, 32'h0004_0010, 0, 32'h1212_1010, 0);
    acc(1, SZ_HALF, 32'h0004_0020, d, 0, 0);
    acc(1, SZ_WORD, 32'h0004_0200, d, 0, 0);
    acc(1, SZ_BYTE, 32'h0004_0201, 32'h3c, 0, 0);
    acc(0, SZ_WORD, 32'h0004_0200, 0, {d[31:16], 8'h3c, d[7:0]}, 0);
    acc(1, SZ_HALF, 32'h01c0_0000, d, 0, 0);
    repeat (4) @(posedge clock);
    final_report;
  end
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
